// ---- gic_defs.svh ----
// Constants shared by the global cell and input cell control logic.
// Assumes a single ref_clk domain; pins arrive asynchronous to it.
// Function
// - Input cell passes pin combinationally by default, or registers or latches it.
// - Registered input cell captures on the clock chosen by global cell C.
// - Latched input cell is transparent while the global cell C clock is high.
// - Single-cell mode: global cell A drives every logic and io cell; B ignored.
// - Dual-cell mode: A drives left-side cells, B drives right-side cells.
// - Logic cell register clock is dedicated clock pin one or two only.
// - Io cell clock is either dedicated pin or its governing cell's product-term clock.
// - Io clock polarity positive by default; negative means falling edge, latch low.
// - Global set forces logic cell register high and wins over clear.
// - Global clear without set forces logic cell register low.
// - Cells with dynamic type enable switch register type while type switch term true.
// - Global cell C provides the single clock for all input cell capture.
// - D-to-T dynamic cell acts as D while switch false, T while true.
`ifndef GIC_DEFS_SVH
`define GIC_DEFS_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define GIC_NUM_LOGIC      8
`define GIC_NUM_IO         8
`define GIC_NUM_INPUT      4
`define GIC_LEFT_COUNT     4

// ****************************************************************
// Bit positions in the synchronised pin vector
// ****************************************************************
`define GIC_CLK_ONE_BIT    0
`define GIC_CLK_TWO_BIT    1
`define GIC_IO_PIN_LSB     2
`define GIC_INPUT_PIN_LSB  (`GIC_IO_PIN_LSB + `GIC_NUM_IO)
`define GIC_PIN_WIDTH      (`GIC_INPUT_PIN_LSB + `GIC_NUM_INPUT)

// ****************************************************************
// Reset values
// ****************************************************************
`define GIC_CELL_RESET     1'b0

`endif

// ---- gic_pkg.sv ----
// Types for the global cell and input cell control logic.
// Assumes gic_defs.svh supplies all numeric constants.
`default_nettype none

package gic_pkg;

    typedef enum logic [1:0] {GIC_IOCLK_PIN_ONE, GIC_IOCLK_PIN_TWO, GIC_IOCLK_PTERM} gic_ioclk_sel_t;
    typedef enum logic [1:0] {GIC_REG_D, GIC_REG_T, GIC_REG_JK} gic_reg_type_t;
    typedef enum logic [1:0] {GIC_INPUT_COMB, GIC_INPUT_REG, GIC_INPUT_LATCH} gic_input_mode_t;

    // Per global cell clock configuration
    typedef struct packed {
        logic           lccClockPinTwo;
        gic_ioclk_sel_t ioClockSel;
        logic           ioClockNeg;
    } gic_global_cfg_t;

    // Per global cell terms from the product-term array
    typedef struct packed {
        logic cellGlobalSet;
        logic cellGlobalClear;
        logic typeSwitchTerm;
        logic productTermClock;
    } gic_global_terms_t;

    // Per logic cell register configuration
    typedef struct packed {
        logic          dynamicTypeEnable;
        gic_reg_type_t baseType;
        gic_reg_type_t altType;
    } gic_lcc_cfg_t;

    // Sum terms feeding a logic cell register: sumA is D, T or J; sumB is K
    typedef struct packed {
        logic sumA;
        logic sumB;
    } gic_lcc_sum_t;

endpackage

`default_nettype wire

// ---- gic_input_cell.sv ----
// One input cell: combinational, registered or latched capture of a pin.
// Assumes pinSync is already synchronised and the capture clock level and
// rising edge are supplied from global cell C on the same ref_clk.
`default_nettype none
`include "gic_defs.svh"

module gic_input_cell
    import gic_pkg::*;
(
    input  wire logic            ref_clk,
    input  wire logic            reset,
    input  wire logic            clockEnable,
    input  wire gic_input_mode_t mode,
    input  wire logic            pinSync,
    input  wire logic            captureLevel,
    input  wire logic            captureRise,
    output var  logic            cellOut
);

    logic next_cellOut;

    // ****************************************************************
    // Capture
    // ****************************************************************
    always_comb begin
        next_cellOut = cellOut;
        unique case (mode)
            GIC_INPUT_COMB:  next_cellOut = pinSync;
            GIC_INPUT_REG:   next_cellOut = captureRise ? pinSync : cellOut;
            GIC_INPUT_LATCH: next_cellOut = captureLevel ? pinSync : cellOut;
            default:         next_cellOut = pinSync;
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cellOut <= `GIC_CELL_RESET;
        end else if (clockEnable) begin
            cellOut <= next_cellOut;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    comb_passes_pin_a: assert property (
        clockEnable && mode == GIC_INPUT_COMB |=> cellOut == $past(pinSync))
        else $error("combinational input cell did not follow pin");
    reg_holds_a: assert property (
        clockEnable && mode == GIC_INPUT_REG && !captureRise |=> $stable(cellOut))
        else $error("registered input cell changed without clock edge");
    latch_open_a: assert property (
        clockEnable && mode == GIC_INPUT_LATCH && captureLevel
        |=> cellOut == $past(pinSync))
        else $error("open latch did not follow pin");

endmodule

`default_nettype wire

// ---- gic_global_cells.sv ----
// Global cells A, B and C with the logic, io and input cell registers they steer.
// Assumes pins are asynchronous to ref_clk and pass two flip-flops here;
// product terms and sum terms come from array logic on ref_clk.
`default_nettype none
`include "gic_defs.svh"

module gic_global_cells
    import gic_pkg::*;
(
    input  wire logic                                 ref_clk,
    input  wire logic                                 reset,
    input  wire logic                                 clockEnable,
    input  wire logic                                 dedicatedClockPinOne,
    input  wire logic                                 dedicatedClockPinTwo,
    input  wire logic                                 dualCellMode,
    input  wire gic_global_cfg_t                      globalCellA,
    input  wire gic_global_cfg_t                      globalCellB,
    input  wire logic                                 inputClockPinTwo,
    input  wire gic_global_terms_t                    termsA,
    input  wire gic_global_terms_t                    termsB,
    input  wire gic_lcc_cfg_t    [`GIC_NUM_LOGIC-1:0] logicCellCfg,
    input  wire gic_lcc_sum_t    [`GIC_NUM_LOGIC-1:0] logicCellSum,
    input  wire logic            [`GIC_NUM_IO-1:0]    ioCellLatch,
    input  wire logic            [`GIC_NUM_IO-1:0]    ioCellPin,
    input  wire gic_input_mode_t [`GIC_NUM_INPUT-1:0] inputCellMode,
    input  wire logic            [`GIC_NUM_INPUT-1:0] inputCellPin,
    output var  logic            [`GIC_NUM_LOGIC-1:0] logicCellQ,
    output var  logic            [`GIC_NUM_IO-1:0]    ioCellQ,
    output var  logic            [`GIC_NUM_INPUT-1:0] inputCellQ
);

    // ****************************************************************
    // Pin synchroniser
    // ****************************************************************
    logic [`GIC_PIN_WIDTH-1:0] pinRaw;
    logic [`GIC_PIN_WIDTH-1:0] pinMeta;
    logic [`GIC_PIN_WIDTH-1:0] pinSync;

    assign pinRaw = {inputCellPin, ioCellPin, dedicatedClockPinTwo, dedicatedClockPinOne};

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pinMeta <= '0;
            pinSync <= '0;
        end else if (clockEnable) begin
            pinMeta <= pinRaw;
            pinSync <= pinMeta;
        end
    end

    // ****************************************************************
    // Clock edge history
    // ****************************************************************
    logic [1:0] clkPrev;
    logic [1:0] next_clkPrev;
    logic [1:0] ioEff;
    logic [1:0] ioEffPrev;
    logic [1:0] next_ioEffPrev;
    logic       pin1Rise;
    logic       pin2Rise;
    logic [1:0] ioRise;

    // pin or product-term clock; polarity applied before edge detect
    function automatic logic ioClockLevel(gic_global_cfg_t cfg, logic pterm,
                                          logic pinOne, logic pinTwo);
        logic level;
        level = pinOne;
        unique case (cfg.ioClockSel)
            GIC_IOCLK_PIN_ONE: level = pinOne;
            GIC_IOCLK_PIN_TWO: level = pinTwo;
            GIC_IOCLK_PTERM:   level = pterm;
            default:           level = pinOne;
        endcase
        return level ^ cfg.ioClockNeg;
    endfunction

    always_comb begin
        ioEff[0] = ioClockLevel(globalCellA, termsA.productTermClock,
                                pinSync[`GIC_CLK_ONE_BIT], pinSync[`GIC_CLK_TWO_BIT]);
        ioEff[1] = ioClockLevel(globalCellB, termsB.productTermClock,
                                pinSync[`GIC_CLK_ONE_BIT], pinSync[`GIC_CLK_TWO_BIT]);
        next_clkPrev   = pinSync[`GIC_CLK_TWO_BIT:`GIC_CLK_ONE_BIT];
        next_ioEffPrev = ioEff;
        pin1Rise = pinSync[`GIC_CLK_ONE_BIT] & ~clkPrev[0];
        pin2Rise = pinSync[`GIC_CLK_TWO_BIT] & ~clkPrev[1];
        ioRise   = ioEff & ~ioEffPrev;
    end

    // Edge history starts low, so a pin already high at release counts as an edge
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            clkPrev   <= '0;
            ioEffPrev <= '0;
        end else if (clockEnable) begin
            clkPrev   <= next_clkPrev;
            ioEffPrev <= next_ioEffPrev;
        end
    end

    // ****************************************************************
    // Logic cell registers
    // ****************************************************************
    logic [`GIC_NUM_LOGIC-1:0] next_logicCellQ;

    // configuration is static, so the cell selection is a plain mux
    for (genvar i = 0; i < `GIC_NUM_LOGIC; i++) begin : g_logic
        localparam bit RIGHT_SIDE = (i >= `GIC_LEFT_COUNT);
        gic_global_cfg_t   cfg;
        gic_global_terms_t trm;
        gic_reg_type_t     kind;
        logic              clkRise;
        logic              q;
        always_comb begin
            q = logicCellQ[i];
            cfg = (dualCellMode && RIGHT_SIDE) ? globalCellB : globalCellA;
            trm = (dualCellMode && RIGHT_SIDE) ? termsB : termsA;
            clkRise = cfg.lccClockPinTwo ? pin2Rise : pin1Rise;
            kind = (logicCellCfg[i].dynamicTypeEnable && trm.typeSwitchTerm)
                 ? logicCellCfg[i].altType : logicCellCfg[i].baseType;
            next_logicCellQ[i] = q;
            if (trm.cellGlobalSet) begin
                next_logicCellQ[i] = 1'b1;
            end else if (trm.cellGlobalClear) begin
                next_logicCellQ[i] = 1'b0;
            end else if (clkRise) begin
                unique case (kind)
                    GIC_REG_D:  next_logicCellQ[i] = logicCellSum[i].sumA;
                    GIC_REG_T:  next_logicCellQ[i] = q ^ logicCellSum[i].sumA;
                    GIC_REG_JK: next_logicCellQ[i] = (logicCellSum[i].sumA & ~q)
                                                   | (~logicCellSum[i].sumB & q);
                    default:    next_logicCellQ[i] = q;
                endcase
            end
        end
    end

    // ****************************************************************
    // Io cell registers and latches
    // ****************************************************************
    logic [`GIC_NUM_IO-1:0] next_ioCellQ;

    for (genvar i = 0; i < `GIC_NUM_IO; i++) begin : g_io
        localparam int CELL = ((i >= `GIC_LEFT_COUNT) ? 1 : 0);
        logic governB;
        logic level;
        logic rise;
        logic din;
        always_comb begin
            governB = dualCellMode && (CELL == 1);
            level   = governB ? ioEff[1] : ioEff[0];
            rise    = governB ? ioRise[1] : ioRise[0];
            din     = pinSync[`GIC_IO_PIN_LSB + i];
            // latch open on effective high, register on effective rise
            if (ioCellLatch[i]) begin
                next_ioCellQ[i] = level ? din : ioCellQ[i];
            end else begin
                next_ioCellQ[i] = rise ? din : ioCellQ[i];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            logicCellQ <= '0;
            ioCellQ    <= '0;
        end else if (clockEnable) begin
            logicCellQ <= next_logicCellQ;
            ioCellQ    <= next_ioCellQ;
        end
    end

    // ****************************************************************
    // Global cell C and input cells
    // ****************************************************************
    logic inputClockLevel;
    logic inputClockRise;

    // one clock for all input cells
    always_comb begin
        inputClockLevel = inputClockPinTwo ? pinSync[`GIC_CLK_TWO_BIT]
                                           : pinSync[`GIC_CLK_ONE_BIT];
        inputClockRise  = inputClockPinTwo ? pin2Rise : pin1Rise;
    end

    for (genvar i = 0; i < `GIC_NUM_INPUT; i++) begin : g_input
        gic_input_cell u_cell (
            .ref_clk      (ref_clk),
            .reset        (reset),
            .clockEnable  (clockEnable),
            .mode         (inputCellMode[i]),
            .pinSync      (pinSync[`GIC_INPUT_PIN_LSB + i]),
            .captureLevel (inputClockLevel),
            .captureRise  (inputClockRise),
            .cellOut      (inputCellQ[i])
        );
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    localparam int LAST = `GIC_NUM_LOGIC - 1;

    set_forces_high_a: assert property (
        clockEnable && termsA.cellGlobalSet |=> logicCellQ[0])
        else $error("global set did not force cell high");
    clear_forces_low_a: assert property (
        clockEnable && termsA.cellGlobalClear && !termsA.cellGlobalSet |=> !logicCellQ[0])
        else $error("global clear did not force cell low");
    single_mode_a: assert property (
        clockEnable && !dualCellMode && termsA.cellGlobalClear && !termsA.cellGlobalSet
        |=> !logicCellQ[LAST])
        else $error("right cell not governed by cell A in single mode");
    dual_mode_right_a: assert property (
        clockEnable && dualCellMode && termsB.cellGlobalSet |=> logicCellQ[LAST])
        else $error("right cell not governed by cell B in dual mode");
    no_edge_hold_a: assert property (
        clockEnable && !pin1Rise && !pin2Rise && !termsA.cellGlobalSet
        && !termsA.cellGlobalClear |=> $stable(logicCellQ[0]))
        else $error("logic cell changed without a dedicated clock edge");
    d_to_t_toggle_a: assert property (
        clockEnable && logicCellCfg[0].dynamicTypeEnable
        && logicCellCfg[0].baseType == GIC_REG_D && logicCellCfg[0].altType == GIC_REG_T
        && termsA.typeSwitchTerm && !termsA.cellGlobalSet && !termsA.cellGlobalClear
        && (globalCellA.lccClockPinTwo ? pin2Rise : pin1Rise)
        |=> logicCellQ[0] == ($past(logicCellQ[0]) ^ $past(logicCellSum[0].sumA)))
        else $error("dynamic cell did not toggle as T");
    pterm_latch_a: assert property (
        clockEnable && ioCellLatch[0] && globalCellA.ioClockSel == GIC_IOCLK_PTERM
        && !globalCellA.ioClockNeg && termsA.productTermClock
        |=> ioCellQ[0] == $past(pinSync[`GIC_IO_PIN_LSB]))
        else $error("io latch not opened by product-term clock");
    neg_latch_low_a: assert property (
        clockEnable && ioCellLatch[0] && globalCellA.ioClockSel == GIC_IOCLK_PIN_ONE
        && globalCellA.ioClockNeg && !pinSync[`GIC_CLK_ONE_BIT]
        |=> ioCellQ[0] == $past(pinSync[`GIC_IO_PIN_LSB]))
        else $error("negative io latch not open on low");
    input_clock_a: assert property (
        clockEnable && inputClockRise && inputCellMode[1] == GIC_INPUT_REG
        |=> inputCellQ[1] == $past(pinSync[`GIC_INPUT_PIN_LSB + 1]))
        else $error("input cell missed the global cell C clock edge");

    cover_dual_split_c: cover property (
        dualCellMode && termsA.cellGlobalSet && termsB.cellGlobalClear);
    cover_type_switch_c: cover property (
        logicCellCfg[0].dynamicTypeEnable && termsA.typeSwitchTerm && pin1Rise);
    cover_input_reg_c: cover property (
        inputCellMode[1] == GIC_INPUT_REG && inputClockRise);
    cover_io_neg_c: cover property (globalCellA.ioClockNeg && ioRise[0]);

endmodule

`default_nettype wire

// ---- gic_pin_model.sv ----
// Pin-side partner: drives the two dedicated clock pins of the device.
// Assumes callers enter its tasks just after a ref_clk rising edge.
`default_nettype none

module gic_pin_model (
    input  wire logic ref_clk,
    output var  logic clockPinOne,
    output var  logic clockPinTwo
);
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************************************
    // Pin drive
    // ****************************************************************
    // Pins stand low outside pulses, as a board clock gated off would
    initial begin
        clockPinOne = 1'b0;
        clockPinTwo = 1'b0;
    end

    task automatic drive(input logic pinTwo, input logic level);
        if (pinTwo) begin
            clockPinTwo = level;
        end else begin
            clockPinOne = level;
        end
    endtask

    // Hold sets prompt or slow edges; under 1 cycle the synchroniser may miss it
    task automatic pulse(input logic pinTwo, input int hold);
        drive(pinTwo, 1'b1);
        repeat (hold) @(posedge ref_clk);
        #1;
        drive(pinTwo, 1'b0);
        repeat (hold) @(posedge ref_clk);
        #1;
    endtask
endmodule

`default_nettype wire

// ---- gic_global_cells_bench.sv ----
// Self-checking bench for the global cells and the cells they steer.
// Assumes one 200 MHz ref_clk; configuration only changes under reset.
`default_nettype none
`include "gic_defs.svh"

module gic_global_cells_bench
    import gic_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;

    logic                  ref_clk;
    logic                  reset;
    logic                  clockEnable;
    logic                  pinOne;
    logic                  pinTwo;
    logic                  dualCellMode;
    logic                  inputClockPinTwo;
    gic_global_cfg_t       cellA;
    gic_global_cfg_t       cellB;
    gic_global_terms_t     termsA;
    gic_global_terms_t     termsB;
    gic_lcc_cfg_t    [7:0] lccCfg;
    gic_lcc_sum_t    [7:0] lccSum;
    logic            [7:0] ioLatch;
    logic            [7:0] ioPin;
    gic_input_mode_t [3:0] inMode;
    logic            [3:0] inPin;
    logic            [7:0] lccQ;
    logic            [7:0] ioQ;
    logic            [3:0] inQ;
    int                    n_mismatch;
    int                    tests_run;
    int                    cycles;

    gic_global_cells dut_u (
        .ref_clk(ref_clk), .reset(reset), .clockEnable(clockEnable),
        .dedicatedClockPinOne(pinOne), .dedicatedClockPinTwo(pinTwo),
        .dualCellMode(dualCellMode), .globalCellA(cellA), .globalCellB(cellB),
        .inputClockPinTwo(inputClockPinTwo), .termsA(termsA), .termsB(termsB),
        .logicCellCfg(lccCfg), .logicCellSum(lccSum), .ioCellLatch(ioLatch),
        .ioCellPin(ioPin), .inputCellMode(inMode), .inputCellPin(inPin),
        .logicCellQ(lccQ), .ioCellQ(ioQ), .inputCellQ(inQ)
    );

    gic_pin_model pins_u (
        .ref_clk(ref_clk), .clockPinOne(pinOne), .clockPinTwo(pinTwo)
    );

    // ****************************************************************
    // Clock, timeout and helpers
    // ****************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Whole run needs about 160 cycles
    initial begin
        cycles = 0;
        forever begin
            @(posedge ref_clk);
            cycles++;
            if (cycles == 3000) begin
                n_mismatch++;
                stop_test();
            end
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic restart();
        reset = 1'b1;
        step(2);
        reset = 1'b0;
        step(1);
    endtask

    task automatic all_sum(input logic val);
        for (int i = 0; i < 8; i++) begin
            lccSum[i].sumA = val;
        end
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        n_mismatch = 0;
        tests_run = 0;
        reset = 1'b1;
        clockEnable = 1'b1;
        dualCellMode = 1'b0;
        inputClockPinTwo = 1'b0;
        {cellA, cellB, termsA, termsB} = '0;
        {lccCfg, lccSum, ioLatch, ioPin, inPin} = '0;
        inMode = '{default: GIC_INPUT_COMB};
        step(8);
        reset = 1'b0;
        step(1);
        check("logic q after reset", 8'h00, lccQ);
        check("io q after reset", 8'h00, ioQ);
        termsB.cellGlobalSet = 1'b1;
        step(2);
        check("cell b ignored", 8'h00, lccQ);
        termsA.cellGlobalSet = 1'b1;
        termsA.cellGlobalClear = 1'b1;
        step(2);
        check("set over clear", 8'hff, lccQ);
        termsA.cellGlobalSet = 1'b0;
        step(2);
        check("clear alone", 8'h00, lccQ);
        termsA = '0;
        dualCellMode = 1'b1;
        restart();
        step(1);
        check("dual right side", 8'hf0, lccQ);
        termsB.cellGlobalSet = 1'b0;
        termsB.cellGlobalClear = 1'b1;
        termsA.cellGlobalSet = 1'b1;
        step(2);
        check("dual left side", 8'h0f, lccQ);
        {termsA, termsB} = '0;
        dualCellMode = 1'b0;
        lccCfg[0].dynamicTypeEnable = 1'b1;
        lccCfg[0].altType = GIC_REG_T;
        lccCfg[1].altType = GIC_REG_T;
        restart();
        all_sum(1'b1);
        pins_u.pulse(1'b1, 3);
        step(2);
        check("pin two not selected", 8'h00, lccQ);
        pins_u.pulse(1'b0, 3);
        step(2);
        check("d load pin one", 8'hff, lccQ);
        termsA.typeSwitchTerm = 1'b1;
        pins_u.pulse(1'b0, 3);
        step(2);
        check("t toggle enabled only", 8'hfe, lccQ);
        termsA.typeSwitchTerm = 1'b0;
        pins_u.pulse(1'b0, 3);
        step(2);
        check("back to d", 8'hff, lccQ);
        cellA.lccClockPinTwo = 1'b1;
        lccCfg[1].baseType = GIC_REG_JK;
        restart();
        lccSum[1].sumB = 1'b1;
        pins_u.pulse(1'b1, 3);
        step(2);
        check("jk sets on pin two", 8'hff, lccQ);
        pins_u.pulse(1'b1, 3);
        step(2);
        check("jk toggles on pin two", 8'hfd, lccQ);
        cellA.ioClockSel = GIC_IOCLK_PTERM;
        ioPin = 8'hff;
        restart();
        step(4);
        termsA.productTermClock = 1'b1;
        step(3);
        check("io pterm rise", 8'hff, ioQ);
        termsA.productTermClock = 1'b0;
        ioPin = 8'h00;
        step(4);
        check("io no load on fall", 8'hff, ioQ);
        cellA.ioClockNeg = 1'b1;
        restart();
        ioPin = 8'hff;
        step(4);
        termsA.productTermClock = 1'b1;
        step(3);
        check("io neg ignores rise", 8'h00, ioQ);
        termsA.productTermClock = 1'b0;
        step(3);
        check("io neg loads fall", 8'hff, ioQ);
        cellA.ioClockNeg = 1'b0;
        cellA.ioClockSel = GIC_IOCLK_PIN_TWO;
        ioLatch = 8'hff;
        restart();
        pins_u.drive(1'b1, 1'b1);
        step(5);
        check("io latch open", 8'hff, ioQ);
        pins_u.drive(1'b1, 1'b0);
        ioPin = 8'h00;
        step(5);
        check("io latch closed", 8'hff, ioQ);
        cellA.ioClockSel = GIC_IOCLK_PTERM;
        termsA.productTermClock = 1'b1;
        restart();
        ioPin = 8'hff;
        step(4);
        check("io pterm latch open", 8'hff, ioQ);
        cellA.ioClockSel = GIC_IOCLK_PIN_ONE;
        cellA.ioClockNeg = 1'b1;
        termsA.productTermClock = 1'b0;
        restart();
        step(4);
        check("neg latch open low", 8'hff, ioQ);
        pins_u.drive(1'b0, 1'b1);
        ioPin = 8'h00;
        step(5);
        check("neg latch shut high", 8'hff, ioQ);
        pins_u.drive(1'b0, 1'b0);
        cellA.ioClockNeg = 1'b0;
        inMode = '{GIC_INPUT_COMB, GIC_INPUT_LATCH, GIC_INPUT_REG, GIC_INPUT_COMB};
        inputClockPinTwo = 1'b1;
        restart();
        inPin = 4'hf;
        step(4);
        check("input comb only", 8'h09, {4'h0, inQ});
        pins_u.pulse(1'b0, 3);
        check("cell c ignores pin one", 8'h09, {4'h0, inQ});
        pins_u.drive(1'b1, 1'b1);
        step(4);
        check("reg and latch load", 8'h0f, {4'h0, inQ});
        inPin = 4'h0;
        step(4);
        check("latch follows", 8'h02, {4'h0, inQ});
        pins_u.drive(1'b1, 1'b0);
        inPin = 4'hf;
        step(4);
        check("latch and reg hold", 8'h0b, {4'h0, inQ});
        stop_test();
    end
endmodule

`default_nettype wire
